// ---- hdl/tws_pkg.sv ----
// Constants shared by the two-wire slave interface: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
`default_nettype none
package tws_pkg;
  localparam logic [7:0] TWS_OFF_DATA = 8'h00;
  localparam logic [7:0] TWS_OFF_OWN_ADDR = 8'h04;
  // The SPI auxiliary control register shares the own-address storage.
  localparam logic [7:0] TWS_OFF_SPI_AUX = TWS_OFF_OWN_ADDR;
  localparam logic [7:0] TWS_OFF_ENABLE = 8'h08;
  localparam logic [7:0] TWS_OFF_CTRL_STAT = 8'h0C;
  localparam int TWS_BIT_IF_ENABLE = 0;
  localparam int TWS_BIT_IDLE_RUN = 1;
  localparam int TWS_BIT_BYTE_DONE = 7;
  localparam int TWS_BIT_ADDR_MATCH = 6;
  localparam int TWS_BIT_BUS_BUSY = 5;
  localparam int TWS_BIT_TX_MODE = 4;
  localparam int TWS_BIT_ACK_SEND = 3;
  localparam int TWS_BIT_MASTER_DIR = 2;
  localparam int TWS_BIT_ACK_RCVD = 0;
  localparam logic [7:0] TWS_RST_DATA = 8'h00;
  localparam logic [7:0] TWS_RST_OWN_ADDR = 8'h00;
  localparam logic [2:0] TWS_LAST_BIT = 3'h7;
  localparam logic [1:0] TWS_RESP_OKAY = 2'h0;
  localparam logic [1:0] TWS_RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_AACKW = 4'b0010,
    ST_AACK = 4'b0011,
    ST_HOLD = 4'b0100,
    ST_RX = 4'b0101,
    ST_RACKW = 4'b0110,
    ST_RACK = 4'b0111,
    ST_TX = 4'b1000,
    ST_TXACK = 4'b1001,
    ST_SKIP = 4'b1010
  } tws_state_t;
endpackage
`default_nettype wire

// ---- hdl/tws_regbus_if.sv ----
// Simple register access strobes between the AXI4-Lite front end and the register file.
// Assumes both ends run on the same clock; hit flags are combinational from the register file.
`timescale 1ns/1ps
`default_nettype none
interface tws_regbus_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_lane0;
  logic wr_hit;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_hit;
  modport bus_side (output wr_en, wr_addr, wr_data, wr_lane0, rd_en, rd_addr,
                    input wr_hit, rd_data, rd_hit);
  modport reg_side (input wr_en, wr_addr, wr_data, wr_lane0, rd_en, rd_addr,
                    output wr_hit, rd_data, rd_hit);
endinterface
`default_nettype wire

// ---- hdl/tws_line_sync.sv ----
// Synchronises the bus clock and data lines and finds the clock edges and START/STOP conditions.
// Assumes the lines are asynchronous to clk and far slower than it.
`timescale 1ns/1ps
`default_nettype none
module tws_line_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic scl_s,
  output logic sda_s,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);
  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic scl_prev;
  logic sda_prev;
  // Lines idle high under the pull-ups, so reset to one to avoid a false edge.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= {scl_meta[0], scl_pin};
      sda_meta <= {sda_meta[0], sda_pin};
      scl_prev <= scl_meta[1];
      sda_prev <= sda_meta[1];
    end
  end
  assign scl_s = scl_meta[1];
  assign sda_s = sda_meta[1];
  assign scl_rise = scl_meta[1] & ~scl_prev;
  assign scl_fall = ~scl_meta[1] & scl_prev;
  assign start_det = scl_meta[1] & scl_prev & sda_prev & ~sda_meta[1];
  assign stop_det = scl_meta[1] & scl_prev & ~sda_prev & sda_meta[1];
endmodule
`default_nettype wire

// ---- hdl/tws_axil_slave.sv ----
// AXI4-Lite slave front end turning bus transfers into single-cycle register strobes.
// Assumes one write and one read outstanding at most; unmapped offsets answer SLVERR.
`timescale 1ns/1ps
`default_nettype none
module tws_axil_slave
  import tws_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  tws_regbus_if.bus_side rb
);
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire ar_take = arvalid & arready;
  wire next_aw_held = (aw_held | aw_take) & ~rb.wr_en;
  wire next_w_held = (w_held | w_take) & ~rb.wr_en;
  wire next_bvalid = rb.wr_en | (bvalid & ~bready);
  wire next_rvalid = ar_take | (rvalid & ~rready);
  assign rb.wr_en = aw_held & w_held & ~bvalid;
  assign rb.wr_addr = aw_addr;
  assign rb.wr_data = w_data;
  assign rb.wr_lane0 = w_lane0;
  assign rb.rd_en = ar_take;
  assign rb.rd_addr = araddr[7:0];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= TWS_RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= TWS_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awready <= ~next_aw_held & ~next_bvalid;
      wready <= ~next_w_held & ~next_bvalid;
      bvalid <= next_bvalid;
      arready <= ~next_rvalid;
      rvalid <= next_rvalid;
      if (aw_take) begin
        aw_addr <= awaddr[7:0];
      end
      if (w_take) begin
        w_data <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end
      if (rb.wr_en) begin
        bresp <= rb.wr_hit ? TWS_RESP_OKAY : TWS_RESP_SLVERR;
      end
      if (ar_take) begin
        rdata <= {24'h00_0000, rb.rd_data};
        rresp <= rb.rd_hit ? TWS_RESP_OKAY : TWS_RESP_SLVERR;
      end
    end
  end
endmodule
`default_nettype wire

// ---- hdl/tws_slave_top.sv ----
// Two-wire bus slave: address match, byte shifting, acknowledge and clock holding.
// Assumes an external master and pull-ups on both lines; registers sit behind AXI4-Lite.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tws_slave_top
  import tws_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic idle_mode,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic bus_irq
);
  tws_regbus_if rb();
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  tws_state_t state;
  tws_state_t next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic next_sda_drv;
  logic next_scl_drv;
  logic [7:0] data_buf;
  logic [7:0] own_addr;
  logic if_enable;
  logic idle_run_enable;
  logic byte_complete_flag;
  logic address_match_flag;
  logic bus_busy_flag;
  logic transmit_mode_select;
  logic ack_to_send;
  logic master_direction_flag;
  logic ack_received_flag;
  logic svc_done;
  logic set_hcf;
  logic clr_hcf;
  logic match_hit;
  logic match_miss;
  logic dir_load;
  logic ack_received_flag_load;
  logic rx_load;
  logic release_hold;

  tws_axil_slave u_axil (
    .clk(clk),
    .rstn(rstn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .rb(rb.bus_side)
  );

  tws_line_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .scl_pin(scl_i),
    .sda_pin(sda_i),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  function automatic logic reg_mapped(input logic [7:0] off);
    reg_mapped = (off == TWS_OFF_DATA) || (off == TWS_OFF_OWN_ADDR) ||
                 (off == TWS_OFF_ENABLE) || (off == TWS_OFF_CTRL_STAT);
  endfunction

  wire [7:0] ctrl_stat = {byte_complete_flag, address_match_flag, bus_busy_flag,
                          transmit_mode_select, ack_to_send, master_direction_flag,
                          1'b0, ack_received_flag};
  wire wr_ok = rb.wr_en & rb.wr_lane0;
  wire wr_data_reg = wr_ok & (rb.wr_addr == TWS_OFF_DATA);
  wire wr_own = wr_ok & (rb.wr_addr == TWS_OFF_OWN_ADDR);
  wire wr_enable = wr_ok & (rb.wr_addr == TWS_OFF_ENABLE);
  wire wr_ctrl = wr_ok & (rb.wr_addr == TWS_OFF_CTRL_STAT);
  wire rd_data_reg = rb.rd_en & (rb.rd_addr == TWS_OFF_DATA);
  wire data_access = wr_data_reg | rd_data_reg;
  // idle mode suspends unless idle-run is set.
  wire active = if_enable & ~(idle_mode & ~idle_run_enable);
  // only bits 7..1 take part in the compare.
  wire addr_equal = (shreg[6:0] == own_addr[7:1]);
  wire last_bit = (cnt == TWS_LAST_BIT);
  wire [7:0] shifted_in = {shreg[6:0], sda_s};
  assign rb.wr_hit = reg_mapped(rb.wr_addr);
  assign rb.rd_hit = reg_mapped(rb.rd_addr);
  assign rb.rd_data = (rb.rd_addr == TWS_OFF_DATA) ? data_buf :
                      (rb.rd_addr == TWS_OFF_OWN_ADDR) ? own_addr :
                      (rb.rd_addr == TWS_OFF_ENABLE) ?
                        {6'h00, idle_run_enable, if_enable} :
                      (rb.rd_addr == TWS_OFF_CTRL_STAT) ? ctrl_stat : 8'h00;

  // only slave states exist; nothing here ever drives a START.
  // data is only pulled while the clock is low or for acknowledge.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_sda_drv = sda_oe;
    next_scl_drv = scl_oe;
    set_hcf = 1'b0;
    clr_hcf = 1'b0;
    match_hit = 1'b0;
    match_miss = 1'b0;
    dir_load = 1'b0;
    ack_received_flag_load = 1'b0;
    rx_load = 1'b0;
    release_hold = 1'b0;
    if (!active || stop_det) begin
      next_state = ST_IDLE;
      next_sda_drv = 1'b0;
      next_scl_drv = 1'b0;
    end else if (start_det) begin
      next_state = ST_ADDR;
      next_cnt = 3'h0;
      next_sda_drv = 1'b0;
      next_scl_drv = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
        end
        // seven address bits MSB first, eighth is direction.
        ST_ADDR: begin
          if (scl_rise) begin
            next_shreg = shifted_in;
            next_cnt = cnt + 3'h1;
            if (last_bit) begin
              dir_load = 1'b1;
              match_hit = addr_equal;
              match_miss = ~addr_equal;
              next_state = addr_equal ? ST_AACKW : ST_SKIP;
            end
          end
        end
        // pull data low across the ninth clock.
        ST_AACKW: begin
          if (scl_fall) begin
            next_sda_drv = 1'b1;
            next_state = ST_AACK;
          end
        end
        // hold the clock after the address acknowledge.
        ST_AACK: begin
          if (scl_fall) begin
            next_sda_drv = 1'b0;
            next_scl_drv = 1'b1;
            next_state = ST_HOLD;
          end
        end
        // release only after a data register access.
        ST_HOLD: begin
          if (svc_done) begin
            release_hold = 1'b1;
            clr_hcf = 1'b1;
            next_scl_drv = 1'b0;
            next_cnt = 3'h0;
            if (transmit_mode_select) begin
              // transmit byte taken from the data register.
              next_shreg = data_buf;
              next_sda_drv = ~data_buf[7];
              next_state = ST_TX;
            end else begin
              next_state = ST_RX;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            next_shreg = shifted_in;
            next_cnt = cnt + 3'h1;
            if (last_bit) begin
              rx_load = 1'b1;
              set_hcf = 1'b1;
              next_state = ST_RACKW;
            end
          end
        end
        // drive the ack-to-send bit on the ninth clock.
        ST_RACKW: begin
          if (scl_fall) begin
            next_sda_drv = ~ack_to_send;
            next_state = ST_RACK;
          end
        end
        // acknowledge ends before the next byte may start.
        ST_RACK: begin
          if (scl_fall) begin
            next_sda_drv = 1'b0;
            next_scl_drv = 1'b1;
            next_state = ST_HOLD;
          end
        end
        // bytes shift out MSB first, changed while the clock is low.
        ST_TX: begin
          if (scl_fall) begin
            if (last_bit) begin
              next_sda_drv = 1'b0;
              next_state = ST_TXACK;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_cnt = cnt + 3'h1;
              next_sda_drv = ~shreg[6];
            end
          end
        end
        // sample the receiver acknowledge on the ninth clock.
        ST_TXACK: begin
          if (scl_rise) begin
            ack_received_flag_load = 1'b1;
          end
          if (scl_fall) begin
            set_hcf = 1'b1;
            // not-acknowledge ends sending with both lines released.
            if (ack_received_flag) begin
              next_state = ST_SKIP;
            end else begin
              next_scl_drv = 1'b1;
              next_state = ST_HOLD;
            end
          end
        end
        // lines stay released until the master's STOP or a repeated START.
        ST_SKIP: begin
        end
        default: begin
          next_state = ST_IDLE;
          next_sda_drv = 1'b0;
          next_scl_drv = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cnt <= 3'h0;
      shreg <= TWS_RST_DATA;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      sda_o <= 1'b0;
      scl_o <= 1'b0;
      bus_irq <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      // the lines are only ever pulled low; high comes from the pull-ups.
      sda_oe <= next_sda_drv;
      scl_oe <= next_scl_drv;
      sda_o <= 1'b0;
      scl_o <= 1'b0;
      // address match and byte end share one interrupt pulse.
      bus_irq <= match_hit | set_hcf;
    end
  end

  // Hardware receive wins over a software write landing in the same cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_buf <= TWS_RST_DATA;
      own_addr <= TWS_RST_OWN_ADDR;
      if_enable <= 1'b0;
      idle_run_enable <= 1'b0;
      transmit_mode_select <= 1'b0;
      ack_to_send <= 1'b0;
    end else begin
      // received byte goes to the data register.
      if (rx_load) begin
        data_buf <= shifted_in;
      end else if (wr_data_reg) begin
        data_buf <= rb.wr_data;
      end
      if (wr_own) begin
        own_addr <= rb.wr_data;
      end
      if (wr_enable) begin
        if_enable <= rb.wr_data[TWS_BIT_IF_ENABLE];
        idle_run_enable <= rb.wr_data[TWS_BIT_IDLE_RUN];
      end
      if (wr_ctrl) begin
        transmit_mode_select <= rb.wr_data[TWS_BIT_TX_MODE];
        ack_to_send <= rb.wr_data[TWS_BIT_ACK_SEND];
      end
    end
  end

  // Flags set by hardware; a set in the same cycle as a clear wins.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      byte_complete_flag <= 1'b0;
      address_match_flag <= 1'b0;
      bus_busy_flag <= 1'b0;
      master_direction_flag <= 1'b0;
      ack_received_flag <= 1'b0;
      svc_done <= 1'b0;
    end else begin
      // low while a data byte shifts, high once that byte is done; the address byte leaves it unchanged.
      byte_complete_flag <= set_hcf | (byte_complete_flag & ~clr_hcf);
      // a miss clears the match flag.
      address_match_flag <= match_hit | (address_match_flag & ~match_miss);
      if (active && start_det) begin
        bus_busy_flag <= 1'b1;
      end else if (active && stop_det) begin
        bus_busy_flag <= 1'b0;
      end
      if (dir_load) begin
        master_direction_flag <= sda_s;
      end
      if (ack_received_flag_load) begin
        ack_received_flag <= sda_s;
      end
      // an access made early is remembered until it releases the hold or a new address matches.
      svc_done <= data_access | (svc_done & ~release_hold & ~match_hit);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_addr_last;
    (state == ST_ADDR) && active && !start_det && !stop_det && scl_rise && last_bit;
  endsequence
  sequence s_rx_last;
    (state == ST_RX) && active && !start_det && !stop_det && scl_rise && last_bit;
  endsequence

  chk_match_sets_irq: assert property (s_addr_last ##0 addr_equal |=>
      address_match_flag && bus_irq && (state == ST_AACKW))
    else $error("address match did not raise flag and interrupt");
  chk_miss_clears: assert property (s_addr_last ##0 !addr_equal |=>
      !address_match_flag && (state == ST_SKIP))
    else $error("address miss did not clear match flag");
  chk_dir_capture: assert property (s_addr_last |=>
      master_direction_flag == $past(sda_s))
    else $error("direction bit not captured from eighth bit");
  chk_addr_ack_low: assert property ((state == ST_AACKW) && active && !start_det &&
      !stop_det && scl_fall |=> sda_oe && !scl_oe)
    else $error("address acknowledge not driven");
  chk_rx_byte_done: assert property (s_rx_last |=>
      byte_complete_flag && bus_irq && (data_buf == $past(shifted_in)))
    else $error("received byte not stored or flagged");
  chk_shift_flag_low: assert property ((state == ST_RX) || (state == ST_TX) |->
      !byte_complete_flag)
    else $error("byte complete flag high while shifting");
  chk_busy_start: assert property (active && start_det |=> bus_busy_flag)
    else $error("busy flag not set on start");
  chk_busy_stop: assert property (active && stop_det && !start_det |=>
      !bus_busy_flag)
    else $error("busy flag not cleared on stop");
  chk_rx_ack_value: assert property ((state == ST_RACKW) && active && !start_det &&
      !stop_det && scl_fall |=> sda_oe == !$past(ack_to_send))
    else $error("receive acknowledge level wrong");
  chk_nack_release: assert property ((state == ST_SKIP) |-> !sda_oe && !scl_oe)
    else $error("lines not released after not-acknowledge");
  chk_hold_clock: assert property ((state == ST_HOLD) && !svc_done && active &&
      !start_det && !stop_det |=> scl_oe && (state == ST_HOLD))
    else $error("clock released without data access");
  chk_disable_idle: assert property (!active |=> (state == ST_IDLE) && !sda_oe &&
      !scl_oe)
    else $error("bus active while disabled or suspended");
endmodule
`default_nettype wire

// ---- testbench/tws_master_model.sv ----
// Behavioural two-wire bus master pulling the open-drain lines low.
// Assumes bench pull-ups; it waits, within a bound, while the slave holds the clock.
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  int stalls = 0;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Line changes land between system clock edges, so no pin moves on a sampling edge.
  task automatic align();
    if ($time % 40 != 0) #(40 - ($time % 40));
  endtask
  task automatic rel_scl();
    int n;
    scl_low = 1'b0;
    for (n = 0; n < 1000 && scl !== 1'b1; n++) #40;
    if (n == 1000) stalls++;
    #160;
  endtask
  task automatic start_c();
    align();
    sda_low = 1'b1;
    #160;
    scl_low = 1'b1;
  endtask
  task automatic stop_c();
    align();
    sda_low = 1'b1;
    #160;
    rel_scl();
    sda_low = 1'b0;
    #320;
  endtask
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    align();
    for (int i = 8; i >= 0; i--) begin
      sda_low = ~tx[i];
      #160;
      rel_scl();
      rx[i] = sda;
      scl_low = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the two-wire slave: AXI4-Lite tasks and a bus master model.
// Assumes pull-ups on both lines, so each line is the AND of all pull-downs.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tws_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, idle_mode = 0;
  logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, scl_o, sda_o, bus_irq;
  logic m_scl, m_sda;
  logic [1:0] bresp, rresp, r;
  logic [7:0] d, adr, b;
  logic [8:0] rx;
  int n_errors = 0, checks = 0, seed = 95108, irqs = 0, q[$];
  wire scl = (scl_oe ? scl_o : 1'b1) & ~m_scl;
  wire sda = (sda_oe ? sda_o : 1'b1) & ~m_sda;
  always #20 clk = ~clk;
  always @(posedge clk) if (bus_irq === 1'b1) irqs++;
  tws_slave_top uut (.clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'h1), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .idle_mode, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe, .bus_irq);
  tws_master_model mm (.scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    summarize();
  endtask
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [7:0] v);
    logic ta, tw, tv;
    tv = 0;
    @(posedge clk);
    awaddr <= {24'h00_0000, a};
    wdata <= {24'h00_0000, v};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int n = 0; n < 50 && !tv; n++) begin
      @(negedge clk);
      ta = awready;
      tw = wready;
      tv = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end
    bready <= 0;
    if (!tv) hang();
  endtask
  task automatic rdc(input string s, input logic [7:0] a, m, e, input logic [1:0] er);
    logic ta, tv;
    tv = 0;
    @(posedge clk);
    araddr <= {24'h00_0000, a};
    arvalid <= 1;
    rready <= 1;
    for (int n = 0; n < 50 && !tv; n++) begin
      @(negedge clk);
      ta = arready;
      tv = rvalid;
      d = rdata[7:0];
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 0;
    end
    rready <= 0;
    if (!tv) hang();
    cmp(s, {er, e}, {r, d & m});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    repeat (2) @(posedge clk);
    rdc("own_addr", TWS_OFF_OWN_ADDR, 8'hFF, TWS_RST_OWN_ADDR, TWS_RESP_OKAY);
    rdc("enable", TWS_OFF_ENABLE, 8'hFF, 8'h00, TWS_RESP_OKAY);
    rdc("unmapped", 8'h10, 8'hFF, 8'h00, TWS_RESP_SLVERR);
    axw(8'h10, 8'h55);
    cmp("bresp", TWS_RESP_SLVERR, r);
    adr = 8'($random(seed));
    axw(TWS_OFF_OWN_ADDR, adr | 8'h01);
    rdc("spi_aux", TWS_OFF_SPI_AUX, 8'hFE, adr & 8'hFE, TWS_RESP_OKAY);
    axw(TWS_OFF_ENABLE, 8'h01);
    for (int k = 0; k < 4; k++) begin
      idle_mode <= (k == 3);
      axw(TWS_OFF_CTRL_STAT, (k == 2) ? 8'h10 : 8'h00);
      mm.start_c();
      mm.xfer({adr[7:1] ^ {6'h00, k == 1}, k == 2, 1'b1}, rx);
      cmp("addr_ack", (k == 1 || k == 3), rx[0]);
      if (k < 3) rdc("status", TWS_OFF_CTRL_STAT, 8'h7C,
        {1'b0, k != 1, 1'b1, k == 2, 1'b0, k == 2, 2'b00}, TWS_RESP_OKAY);
      if (k == 0) begin
        rdc("dummy", TWS_OFF_DATA, 8'h00, 8'h00, TWS_RESP_OKAY);
        for (int j = 0; j < 2; j++) begin
          b = 8'($random(seed));
          q.push_back(b);
          axw(TWS_OFF_CTRL_STAT, j ? 8'h08 : 8'h00);
          mm.xfer({b, 1'b1}, rx);
          cmp("rx_ack", j, rx[0]);
          rdc("done", TWS_OFF_CTRL_STAT, 8'h80, 8'h80, TWS_RESP_OKAY);
          rdc("rx_data", TWS_OFF_DATA, 8'hFF, 8'(q.pop_front()), TWS_RESP_OKAY);
        end
      end
      if (k == 2) begin
        b = 8'($random(seed));
        axw(TWS_OFF_DATA, b);
        mm.xfer(9'h1FF, rx);
        cmp("tx_data", b, rx[8:1]);
        repeat (6) @(posedge clk);
        cmp("sda_free", 1, sda);
        cmp("scl_free", 0, scl_oe);
        rdc("nack", TWS_OFF_CTRL_STAT, 8'h81, 8'h81, TWS_RESP_OKAY);
      end
      mm.stop_c();
      if (k < 3) rdc("idle", TWS_OFF_CTRL_STAT, 8'h20, 8'h00, TWS_RESP_OKAY);
    end
    cmp("irqs", 5, irqs);
    cmp("stalls", 0, mm.stalls);
    summarize();
  end
endmodule
`default_nettype wire
